// ==== hdl/sbp_cfg.svh ====
// Purpose: offsets, field positions, reset values and limits of the scan buffer block
// Assumes: included by the package, the top module and the testbench
// Notes: parameters are fixed-point in units of 1e-4, bias in whole volts
`ifndef SBP_CFG_SVH
`define SBP_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SBP_OFF_CMD 8'h00
`define SBP_OFF_ARG 8'h04
`define SBP_OFF_STATUS 8'h08
`define SBP_OFF_GAIN 8'h0c
`define SBP_OFF_BIAS 8'h10
`define SBP_OFF_PSENS 8'h14
`define SBP_OFF_TSENS 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SBP_CMD_HAS_ARG 4
`define SBP_CMD_QUERY 5
`define SBP_ST_BUSY 0
`define SBP_ST_FLAG 1
`define SBP_ST_ERR_CMD 2
`define SBP_ST_ERR_PAR 3

// ----------------------------------------------------------------
// sizes, reset values and limits
// ----------------------------------------------------------------
`define SBP_DEPTH 64
`define SBP_PAR_RESET 32'h00000000
`define SBP_GAIN_MAX 32'h01312d00
`define SBP_BIAS_MAX 32'h000009ba
`define SBP_PSENS_MAX 32'h000186a0
`define SBP_TSENS_MAX 32'h000f4240
`define SBP_REPLY_LEN 4'ha
`define SBP_ASCII_LF 8'h0a
`define SBP_ASCII_CR 8'h0d

`endif

// ==== hdl/sbp_pkg.sv ====
// Purpose: types of the scan buffer and parameter store block
// Assumes: constants come from sbp_cfg.svh
// Notes: the whole block state is one packed struct
`include "sbp_cfg.svh"

package sbp_pkg;

  // ----------------------------------------------------------------
  // states and command codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SBP_IDLE, SBP_DRAIN, SBP_SCAN, SBP_MEAS} sbp_state_type;

  typedef enum logic [2:0] {
    SBP_OP_TP = 3'h0, SBP_OP_MG = 3'h1, SBP_OP_MV = 3'h2,
    SBP_OP_SP = 3'h3, SBP_OP_ST = 3'h4, SBP_OP_SC = 3'h5
  } sbp_op_type;

  // ----------------------------------------------------------------
  // complete block state
  // ----------------------------------------------------------------
  typedef struct packed {
    sbp_state_type st;
    logic flag;
    logic cont;
    logic from_scan;
    logic [7:0] left;
    logic err_cmd;
    logic err_par;
    logic [31:0] arg;
    logic [31:0] gain;
    logic [31:0] bias;
    logic [31:0] psens;
    logic [31:0] tsens;
    logic [`SBP_DEPTH-1:0][31:0] mem;
    logic [5:0] wr;
    logic [5:0] rd;
    logic [6:0] cnt;
    logic [1:0] bsel;
    logic [31:0] rval;
    logic [3:0] rcnt;
    logic tx_valid;
    logic [7:0] tx_data;
    logic abort;
    logic start;
    logic tpreq;
    logic meas_on;
    logic scan_ready;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sbp_regs_type;

endpackage : sbp_pkg

// ==== hdl/sbp_top.sv ====
// Purpose: command handling, scan buffering and parameter store of an analyser head
// Assumes: scan engine, electrometer and serial line run on i_clk
// Notes: commands arrive as APB writes; the host stream leaves on the tx port
//
// How it works
// - any command during a scan aborts it, flushes buffer, then runs
// - buffer holds up to 64 words of a scan, each kept until it has been sent
// - scan trigger waits until earlier buffered data is fully sent
// - total pressure request issued automatically after every scan while flag is set
// - flag set: measure and send the total ion current
// - flag clear: skip measurement, still send a null current
// - flag set at reset, cleared when the multiplier switches on
// - argument 0 clears flag, 1 sets it, query triggers a measurement
// - current sent as 4-byte two's complement, low byte first
// - during measurement rf sits at 1 amu point, dc bias zero
// - pressure command without argument is an error
// - gain accepts 0 to 2000.0000 thousands, stored, read back
// - stored gain never applied to measured currents
// - gain and bias commands without multiplier option are bad commands
// - bias accepts 0 to 2490 volts, stored, never drives multiplier
// - gain and bias commands without argument are errors
// - partial sensitivity accepts 0 to 10.0000, stored, read back
// - total sensitivity accepts 0 to 100.0000, stored, read back
// - stored partial sensitivity never used to convert currents
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "sbp_cfg.svh"

module sbp_top
  import sbp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  input wire logic i_em_on,
  input wire logic i_em_option,
  output logic o_scan_start,
  output logic o_scan_abort,
  input wire logic i_scan_valid,
  input wire logic [31:0] i_scan_word,
  input wire logic i_scan_done,
  output logic o_scan_ready,
  output logic o_tp_req,
  input wire logic i_tp_done,
  input wire logic [31:0] i_tp_current,
  output logic o_rf_one_amu,
  output logic o_dc_zero,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] sbp_hex(input logic [3:0] n);
    if (n < 4'ha) begin
      return 8'h30 + {4'h0, n};
    end
    return 8'h57 + {4'h0, n};
  endfunction : sbp_hex

  sbp_regs_type s_reg;
  sbp_regs_type s_next;
  logic apb_wr;
  logic apb_rd;
  logic w_cmd;
  logic mapped;
  sbp_op_type op;
  logic has_arg;
  logic query;
  logic room;
  logic [31:0] word;
  logic [31:0] lim;

  // apb access phase, write lands at the edge where pready is seen high
  assign apb_wr = i_psel && i_penable && i_pwrite && s_reg.pready;
  assign apb_rd = i_psel && i_penable && !i_pwrite && !s_reg.pready;
  assign w_cmd = apb_wr && (i_paddr == `SBP_OFF_CMD);
  assign op = sbp_op_type'(i_pwdata[2:0]);
  assign has_arg = i_pwdata[`SBP_CMD_HAS_ARG];
  assign query = i_pwdata[`SBP_CMD_QUERY];
  assign room = (s_reg.cnt != 7'(`SBP_DEPTH));
  assign word = s_reg.mem[s_reg.rd];
  assign mapped = (i_paddr[1:0] == 2'h0) && (i_paddr <= `SBP_OFF_TSENS);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.abort = 1'b0;
    s_next.start = 1'b0;
    s_next.tpreq = 1'b0;
    lim = 32'h0;

    // apb answer: one wait cycle, read data latched before pready
    s_next.pready = i_psel && i_penable && !s_reg.pready;
    if (i_psel && i_penable && !s_reg.pready) begin
      s_next.pslverr = !mapped;
    end
    if (apb_rd) begin
      case (i_paddr)
        `SBP_OFF_ARG: s_next.prdata = s_reg.arg;
        `SBP_OFF_STATUS: begin
          s_next.prdata = 32'h0;
          s_next.prdata[`SBP_ST_BUSY] = (s_reg.st != SBP_IDLE);
          s_next.prdata[`SBP_ST_FLAG] = s_reg.flag;
          s_next.prdata[`SBP_ST_ERR_CMD] = s_reg.err_cmd;
          s_next.prdata[`SBP_ST_ERR_PAR] = s_reg.err_par;
          s_next.prdata[14:8] = s_reg.cnt;
        end
        `SBP_OFF_GAIN: s_next.prdata = s_reg.gain;
        `SBP_OFF_BIAS: s_next.prdata = s_reg.bias;
        `SBP_OFF_PSENS: s_next.prdata = s_reg.psens;
        `SBP_OFF_TSENS: s_next.prdata = s_reg.tsens;
        default: s_next.prdata = 32'h0;
      endcase
    end
    if (apb_wr && (i_paddr == `SBP_OFF_ARG)) begin
      s_next.arg = i_pwdata;
    end
    // write one clears an error bit; later sets in this cycle win
    if (apb_wr && (i_paddr == `SBP_OFF_STATUS)) begin
      if (i_pwdata[`SBP_ST_ERR_CMD]) begin
        s_next.err_cmd = 1'b0;
      end
      if (i_pwdata[`SBP_ST_ERR_PAR]) begin
        s_next.err_par = 1'b0;
      end
    end

    // low byte first
    // tx byte stage: ascii reply first, then buffered words
    if (!s_reg.tx_valid || i_tx_ready) begin
      s_next.tx_valid = 1'b0;
      if (s_reg.rcnt != 4'h0) begin
        s_next.tx_valid = 1'b1;
        s_next.rcnt = s_reg.rcnt - 4'h1;
        case (s_reg.rcnt)
          4'h2: s_next.tx_data = `SBP_ASCII_LF;
          4'h1: s_next.tx_data = `SBP_ASCII_CR;
          default: s_next.tx_data = sbp_hex(s_reg.rval[31:28]);
        endcase
        if (s_reg.rcnt > 4'h2) begin
          s_next.rval = {s_reg.rval[27:0], 4'h0};
        end
      end else if (s_reg.cnt != 7'h0) begin
        s_next.tx_valid = 1'b1;
        s_next.tx_data = word[8*s_reg.bsel +: 8];
        s_next.bsel = s_reg.bsel + 2'h1;
        if (s_reg.bsel == 2'h3) begin
          s_next.rd = s_reg.rd + 6'h1;
          s_next.cnt = s_next.cnt - 7'h1;
        end
      end
    end

    // scan and measurement sequencing
    case (s_reg.st)
      SBP_IDLE: begin
      end
      SBP_DRAIN: begin
        if (s_reg.cnt == 7'h0 && s_reg.rcnt == 4'h0 && !s_reg.tx_valid) begin
          s_next.start = 1'b1;
          s_next.st = SBP_SCAN;
          if (!s_reg.cont) begin
            s_next.left = s_reg.left - 8'h1;
          end
        end
      end
      SBP_SCAN: begin
        if (i_scan_valid && s_reg.scan_ready) begin
          s_next.mem[s_reg.wr] = i_scan_word;
          s_next.wr = s_reg.wr + 6'h1;
          s_next.cnt = s_next.cnt + 7'h1;
        end
        // pressure after scan
        // a multiplier switch-on in the same cycle clears the flag first, so no request
        if (i_scan_done) begin
          s_next.st = SBP_MEAS;
          s_next.from_scan = 1'b1;
          s_next.tpreq = s_reg.flag && !i_em_on;
        end
      end
      SBP_MEAS: begin
        if (room && (i_tp_done || !s_reg.flag)) begin
          s_next.mem[s_reg.wr] = s_reg.flag ? i_tp_current : 32'h0;
          s_next.wr = s_reg.wr + 6'h1;
          s_next.cnt = s_next.cnt + 7'h1;
          s_next.st = SBP_IDLE;
          if (s_reg.from_scan && (s_reg.cont || s_reg.left != 8'h0)) begin
            s_next.st = SBP_DRAIN;
          end
        end
      end
      default: s_next.st = SBP_IDLE;
    endcase

    if (i_em_on) begin
      s_next.flag = 1'b0;
    end

    if (w_cmd) begin
      if (s_reg.st != SBP_IDLE) begin
        s_next.abort = 1'b1;
        s_next.st = SBP_IDLE;
        s_next.start = 1'b0;
        s_next.tpreq = 1'b0;
        s_next.cnt = 7'h0;
        s_next.wr = 6'h0;
        s_next.rd = 6'h0;
        s_next.bsel = 2'h0;
        s_next.rcnt = 4'h0;
        s_next.tx_valid = 1'b0;
      end
      s_next.from_scan = 1'b0;
      case (op)
        SBP_OP_TP: begin
          if (query) begin
            s_next.st = SBP_MEAS;
            s_next.tpreq = s_next.flag;
          end else if (!has_arg) begin
            s_next.err_par = 1'b1;
          end else if (s_reg.arg == 32'h0) begin
            s_next.flag = 1'b0;
          end else if (s_reg.arg == 32'h1 && !i_em_on) begin
            s_next.flag = 1'b1;
          end else if (s_reg.arg != 32'h1) begin
            s_next.err_par = 1'b1;
          end
        end
        SBP_OP_SC: begin
          if (query || (has_arg && s_reg.arg > 32'h000000ff)) begin
            s_next.err_par = 1'b1;
          end else if (!has_arg || s_reg.arg != 32'h0) begin
            s_next.cont = !has_arg;
            s_next.left = s_reg.arg[7:0];
            s_next.st = SBP_DRAIN;
          end
        end
        SBP_OP_MG, SBP_OP_MV, SBP_OP_SP, SBP_OP_ST: begin
          case (op)
            SBP_OP_MG: lim = `SBP_GAIN_MAX;
            SBP_OP_MV: lim = `SBP_BIAS_MAX;
            SBP_OP_SP: lim = `SBP_PSENS_MAX;
            default: lim = `SBP_TSENS_MAX;
          endcase
          if ((op == SBP_OP_MG || op == SBP_OP_MV) && !i_em_option) begin
            s_next.err_cmd = 1'b1;
          end else if (query) begin
            s_next.rcnt = `SBP_REPLY_LEN;
            case (op)
              SBP_OP_MG: s_next.rval = s_reg.gain;
              SBP_OP_MV: s_next.rval = s_reg.bias;
              SBP_OP_SP: s_next.rval = s_reg.psens;
              default: s_next.rval = s_reg.tsens;
            endcase
          end else if (!has_arg || s_reg.arg > lim) begin
            s_next.err_par = 1'b1;
          end else begin
            case (op)
              SBP_OP_MG: s_next.gain = s_reg.arg;
              SBP_OP_MV: s_next.bias = s_reg.arg;
              SBP_OP_SP: s_next.psens = s_reg.arg;
              default: s_next.tsens = s_reg.arg;
            endcase
          end
        end
        default: s_next.err_cmd = 1'b1;
      endcase
    end

    s_next.meas_on = (s_next.st == SBP_MEAS);
    // ready registered, so it must already allow for this cycle's push
    s_next.scan_ready = (s_next.st == SBP_SCAN) && (s_next.cnt != 7'(`SBP_DEPTH));
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_reg <= '0;
      s_reg.st <= SBP_IDLE;
      s_reg.flag <= 1'b1;
      s_reg.gain <= `SBP_PAR_RESET;
      s_reg.bias <= `SBP_PAR_RESET;
      s_reg.psens <= `SBP_PAR_RESET;
      s_reg.tsens <= `SBP_PAR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign o_pready = s_reg.pready;
  assign o_pslverr = s_reg.pslverr;
  assign o_prdata = s_reg.prdata;
  assign o_scan_start = s_reg.start;
  assign o_scan_abort = s_reg.abort;
  assign o_scan_ready = s_reg.scan_ready;
  assign o_tp_req = s_reg.tpreq;
  assign o_rf_one_amu = s_reg.meas_on;
  assign o_dc_zero = s_reg.meas_on;
  assign o_tx_valid = s_reg.tx_valid;
  assign o_tx_data = s_reg.tx_data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence seq_drain_empty;
    s_reg.st == SBP_DRAIN && s_reg.cnt == 7'h0 && s_reg.rcnt == 4'h0 && !s_reg.tx_valid;
  endsequence
  sequence seq_start_scan;
    s_reg.start && s_reg.st == SBP_SCAN;
  endsequence

  chk_abort_flush: assert property (
    w_cmd && s_reg.st == SBP_SCAN |=> o_scan_abort && s_reg.cnt == 7'h0 && !o_tx_valid)
    else $error("command during scan did not abort and flush");
  chk_start_empty: assert property (
    s_reg.start |-> $past(s_reg.cnt) == 7'h0 && $past(s_reg.st) == SBP_DRAIN)
    else $error("scan started with data pending");
  chk_drain_start: assert property (
    seq_drain_empty ##0 !w_cmd |=> seq_start_scan)
    else $error("empty buffer did not start scan");
  chk_scan_to_tp: assert property (
    s_reg.st == SBP_SCAN && i_scan_done && !w_cmd |=> s_reg.st == SBP_MEAS ##0 o_tp_req == s_reg.flag)
    else $error("no pressure request after scan");
  chk_tp_current: assert property (
    s_reg.st == SBP_MEAS && s_reg.flag && i_tp_done && room && !w_cmd
    |=> s_reg.mem[$past(s_reg.wr)] == $past(i_tp_current))
    else $error("measured current not buffered");
  chk_tp_null: assert property (
    s_reg.st == SBP_MEAS && !s_reg.flag && room && !w_cmd
    |=> s_reg.mem[$past(s_reg.wr)] == 32'h0 && s_reg.st != SBP_MEAS)
    else $error("null current not buffered");
  chk_flag_em_on: assert property (
    i_em_on |=> !s_reg.flag)
    else $error("flag survived multiplier switch on");
  chk_rf_dc_meas: assert property (
    (s_reg.st == SBP_MEAS) == (o_rf_one_amu && o_dc_zero))
    else $error("rf and dc not set during measurement");
  chk_gain_range: assert property (
    w_cmd && op == SBP_OP_MG && i_em_option && !query && s_reg.arg > `SBP_GAIN_MAX
    |=> s_reg.gain == $past(s_reg.gain) && s_reg.err_par)
    else $error("out of range gain accepted");
  chk_no_option: assert property (
    w_cmd && (op == SBP_OP_MV || op == SBP_OP_MG) && !i_em_option
    |=> s_reg.err_cmd && $stable(s_reg.bias) && $stable(s_reg.gain))
    else $error("multiplier command accepted without option");
  chk_tp_noarg: assert property (
    w_cmd && op == SBP_OP_TP && !query && !has_arg |=> s_reg.err_par)
    else $error("pressure command without argument not flagged");

endmodule : sbp_top

// ==== test/sbp_host_model.sv ====
// Purpose: host serial line, scan engine and electrometer beside the block
// Assumes: one clock; every output changes just after a rising edge
// Notes: scan words and currents are random; received bytes are queued
`timescale 1ns/1ns

module sbp_host_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_stall,
  input wire logic [7:0] i_words,
  input wire logic i_scan_start,
  input wire logic i_scan_abort,
  input wire logic i_scan_ready,
  input wire logic i_tp_req,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_scan_valid,
  output logic [31:0] o_scan_word,
  output logic o_scan_done,
  output logic o_tp_done,
  output logic [31:0] o_tp_current,
  output logic o_tx_ready
);
  integer seed = 42315;
  integer left = 0;
  integer tp_wait = 0;
  integer n_start = 0;
  integer n_abort = 0;
  logic [31:0] cur;
  logic [31:0] word_q[$];
  logic [31:0] cur_q[$];
  logic [7:0] rx_q[$];

  // ----------------------------------------------------------------
  // far side behaviour
  // ----------------------------------------------------------------
  initial begin
    {o_scan_valid, o_scan_word, o_scan_done} = '0;
    {o_tp_done, o_tp_current, o_tx_ready} = '0;
  end

  // current bus changes every cycle so a stale read never matches
  always @(posedge i_clk) begin
    cur = $random(seed);
    o_scan_done <= 1'b0;
    o_tp_done <= 1'b0;
    o_tp_current <= cur;
    // host takes the stream at its own, often slow, pace
    o_tx_ready <= !i_stall && (cur[1:0] != 2'b00);
    if (i_tx_valid && o_tx_ready) rx_q.push_back(i_tx_data);
    if (o_scan_valid && i_scan_ready) word_q.push_back(o_scan_word);
    if (i_scan_abort) n_abort++;
    if (!i_rst_n || i_scan_abort) begin
      left = 0;
      tp_wait = 0;
      o_scan_valid <= 1'b0;
    end else begin
      if (i_scan_start) begin
        n_start++;
        left = i_words;
      end else if (!o_scan_valid || i_scan_ready) begin
        o_scan_valid <= (left > 0);
        o_scan_word <= $random(seed);
        o_scan_done <= o_scan_valid && (left == 0);
        if (left > 0) left--;
      end
      if (i_tp_req) tp_wait = 3;
      else if (tp_wait > 0) begin
        tp_wait--;
        if (tp_wait == 0) begin
          o_tp_done <= 1'b1;
          cur_q.push_back(cur);
        end
      end
    end
  end
endmodule : sbp_host_model

// ==== test/sbp_top_tb.sv ====
// Purpose: self-checking bench of the scan buffer and parameter store
// Assumes: APB master here, far side in sbp_host_model
// Notes: expected byte stream kept in a queue and compared per result
`timescale 1ns/1ns
`include "sbp_cfg.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module sbp_top_tb;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0] paddr = 0, a, b1, b2;
  logic [7:0] words = 8'h04;
  logic [31:0] pwdata = 0, r, v, mx;
  logic em_on = 0, em_option = 1, stall = 0, flag_m = 1;
  logic pready, pslverr, sstart, sabort, svalid, sdone, sready, tpreq, tpdone;
  logic rf, dc, txv, txr;
  logic [31:0] prdata, sword, tpcur;
  logic [7:0] txd;
  logic [31:0] lim [0:3];
  logic [7:0] exp_q[$];
  integer mismatches = 0, check_count = 0, cycles = 0, seed = 42315, i, k, n0;

  sbp_top i_sbp_top (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .i_em_on(em_on), .i_em_option(em_option),
    .o_scan_start(sstart), .o_scan_abort(sabort), .i_scan_valid(svalid),
    .i_scan_word(sword), .i_scan_done(sdone), .o_scan_ready(sready), .o_tp_req(tpreq),
    .i_tp_done(tpdone), .i_tp_current(tpcur), .o_rf_one_amu(rf), .o_dc_zero(dc),
    .o_tx_valid(txv), .o_tx_data(txd), .i_tx_ready(txr));
  sbp_host_model i_sbp_host_model (.i_clk(clk), .i_rst_n(rst_n), .i_stall(stall),
    .i_words(words), .i_scan_start(sstart), .i_scan_abort(sabort), .i_scan_ready(sready),
    .i_tp_req(tpreq), .i_tx_valid(txv), .i_tx_data(txd), .o_scan_valid(svalid),
    .o_scan_word(sword), .o_scan_done(sdone), .o_tp_done(tpdone), .o_tp_current(tpcur),
    .o_tx_ready(txr));

  // ----------------------------------------------------------------
  // clock, timeout and measurement monitor
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (tpreq === 1'b1) begin
      `CHK("flag at request", 1'b1, flag_m)
      `CHK("rf and dc", 2'b11, {rf, dc})
    end
    if (cycles > 20000) begin
      mismatches++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // fl is {query, has_arg}
  task cmd(input logic [2:0] op, input logic [1:0] fl, input logic [31:0] arg);
    apb(1'b1, `SBP_OFF_ARG, arg);
    apb(1'b1, `SBP_OFF_CMD, {26'h0, fl, 1'b0, op});
  endtask : cmd
  task chk_err(input logic [1:0] ex);
    apb(1'b0, `SBP_OFF_STATUS, 32'h0);
    `CHK("error bits", ex, r[3:2])
    apb(1'b1, `SBP_OFF_STATUS, 32'hc);
  endtask : chk_err
  task push_word(input logic [31:0] w);
    for (k = 0; k < 4; k++) exp_q.push_back(w[8*k +: 8]);
  endtask : push_word
  task push_hex(input logic [31:0] w);
    for (k = 7; k >= 0; k--) exp_q.push_back(w[4*k +: 4] < 4'ha ?
      8'h30 + {4'h0, w[4*k +: 4]} : 8'h57 + {4'h0, w[4*k +: 4]});
    exp_q.push_back(`SBP_ASCII_LF);
    exp_q.push_back(`SBP_ASCII_CR);
  endtask : push_hex
  task wait_cur();
    for (k = 0; k < 500 && i_sbp_host_model.cur_q.size() == 0; k++) @(posedge clk);
  endtask : wait_cur
  task expect_rx();
    for (i = 0; i < 3000 && i_sbp_host_model.rx_q.size() < exp_q.size(); i++) @(posedge clk);
    repeat (20) @(posedge clk);
    `CHK("byte count", exp_q.size(), i_sbp_host_model.rx_q.size())
    while (exp_q.size() > 0 && i_sbp_host_model.rx_q.size() > 0) begin
      b1 = exp_q.pop_front();
      b2 = i_sbp_host_model.rx_q.pop_front();
      `CHK("stream byte", b1, b2)
    end
    exp_q.delete();
    i_sbp_host_model.rx_q.delete();
  endtask : expect_rx
  task conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    lim = '{`SBP_GAIN_MAX, `SBP_BIAS_MAX, `SBP_PSENS_MAX, `SBP_TSENS_MAX};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `SBP_OFF_STATUS, 32'h0);
    `CHK("status after reset", 32'h2, r)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped read", 33'h100000000, {e, r})
    for (n0 = 0; n0 < 4; n0++) begin
      a = `SBP_OFF_GAIN + 8'(4 * n0);
      mx = lim[n0];
      apb(1'b0, a, 32'h0);
      `CHK("parameter reset", `SBP_PAR_RESET, r)
      v = {$random(seed)} % (mx + 1);
      cmd(3'(n0 + 1), 2'b01, v);
      apb(1'b0, a, 32'h0);
      `CHK("parameter", v, r)
      cmd(3'(n0 + 1), 2'b01, mx + 1);
      chk_err(2'b10);
      apb(1'b0, a, 32'h0);
      `CHK("parameter kept", v, r)
      cmd(3'(n0 + 1), 2'b01, mx);
      cmd(3'(n0 + 1), 2'b10, 32'h0);
      push_hex(mx);
      expect_rx();
    end
    em_option <= 1'b0;
    cmd(3'h1, 2'b01, 32'h5);
    chk_err(2'b01);
    cmd(3'h2, 2'b01, 32'h5);
    chk_err(2'b01);
    apb(1'b0, `SBP_OFF_GAIN, 32'h0);
    `CHK("gain untouched", `SBP_GAIN_MAX, r)
    em_option <= 1'b1;
    cmd(3'h1, 2'b00, 32'h0);
    chk_err(2'b10);
    cmd(3'h2, 2'b00, 32'h0);
    chk_err(2'b10);
    cmd(3'h0, 2'b00, 32'h0);
    chk_err(2'b10);
    cmd(3'h6, 2'b01, 32'h0);
    chk_err(2'b01);
    // multiplier on clears flag; query sends a null
    em_on <= 1'b1;
    @(posedge clk);
    em_on <= 1'b0;
    flag_m = 1'b0;
    apb(1'b0, `SBP_OFF_STATUS, 32'h0);
    `CHK("flag after em on", 1'b0, r[1])
    cmd(3'h0, 2'b10, 32'h0);
    push_word(32'h0);
    expect_rx();
    cmd(3'h0, 2'b01, 32'h1);
    flag_m = 1'b1;
    apb(1'b0, `SBP_OFF_STATUS, 32'h0);
    `CHK("flag after set", 1'b1, r[1])
    cmd(3'h0, 2'b10, 32'h0);
    wait_cur();
    push_word(i_sbp_host_model.cur_q.pop_front());
    expect_rx();
    cmd(3'h5, 2'b01, 32'h1);
    wait_cur();
    while (i_sbp_host_model.word_q.size() > 0) push_word(i_sbp_host_model.word_q.pop_front());
    push_word(i_sbp_host_model.cur_q.pop_front());
    expect_rx();
    // second trigger waits for pending data
    cmd(3'h0, 2'b01, 32'h0);
    flag_m = 1'b0;
    stall <= 1'b1;
    n0 = i_sbp_host_model.n_start;
    cmd(3'h5, 2'b01, 32'h1);
    for (k = 0; k < 500 && i_sbp_host_model.word_q.size() < 4; k++) @(posedge clk);
    repeat (5) @(posedge clk);
    cmd(3'h5, 2'b01, 32'h1);
    repeat (30) @(posedge clk);
    `CHK("no early start", n0 + 1, i_sbp_host_model.n_start)
    stall <= 1'b0;
    for (k = 0; k < 3000 && i_sbp_host_model.n_start < n0 + 2; k++) @(posedge clk);
    `CHK("sent before start", 20, i_sbp_host_model.rx_q.size())
    for (k = 0; k < 500 && i_sbp_host_model.word_q.size() < 8; k++) @(posedge clk);
    for (n0 = 0; n0 < 8; n0++) begin
      push_word(i_sbp_host_model.word_q.pop_front());
      if (n0 % 4 == 3) push_word(32'h0);
    end
    expect_rx();
    // command mid-scan aborts, host flushes, command runs
    words <= 8'd40;
    stall <= 1'b1;
    n0 = i_sbp_host_model.n_start;
    cmd(3'h5, 2'b00, 32'h0);
    for (k = 0; k < 500 && i_sbp_host_model.n_start == n0; k++) @(posedge clk);
    repeat (5) @(posedge clk);
    cmd(3'h0, 2'b10, 32'h0);
    repeat (3) @(posedge clk);
    i_sbp_host_model.rx_q.delete();
    i_sbp_host_model.word_q.delete();
    stall <= 1'b0;
    push_word(32'h0);
    expect_rx();
    `CHK("abort pulses", 1, i_sbp_host_model.n_abort)
    `CHK("scan stopped", n0 + 1, i_sbp_host_model.n_start)
    conclude();
  end
endmodule : sbp_top_tb
